// ### core/uhri_pkg.sv
/*
 * Shared constants for the serial channel host register interface:
 * register offsets, field positions, reset values, state codes and timing.
 * Assumes a 40 MHz core clock and a 3-bit host address bus.
 */
package uhri_pkg;
   // =========================================================
   // register offsets on the three host address lines
   localparam logic [2:0] OFS_DATA = 3'h0;
   localparam logic [2:0] OFS_IER = 3'h1;
   localparam logic [2:0] OFS_IIR = 3'h2;
   localparam logic [2:0] OFS_LCR = 3'h3;
   localparam logic [2:0] OFS_MCR = 3'h4;
   localparam logic [2:0] OFS_LSR = 3'h5;
   localparam logic [2:0] OFS_MSR = 3'h6;
   localparam logic [2:0] OFS_SPR = 3'h7;

   // =========================================================
   // field positions
   localparam int LCR_DLAB_BIT = 7;
   localparam int EFR_ENH_BIT = 4;
   localparam int IER_RX_BIT = 0;
   localparam int IER_THRE_BIT = 1;
   localparam int IER_MS_BIT = 3;
   localparam int FCR_EN_BIT = 0;
   localparam logic [7:0] LCR_EFR_KEY = 8'hbf;
   localparam logic [7:0] IER_GUARD_MASK = 8'hf0;
   localparam logic [7:0] MCR_GUARD_MASK = 8'he0;
   localparam logic [7:0] FCR_GUARD_MASK = 8'h30;

   // =========================================================
   // reset values
   localparam logic [7:0] DATA_RST = 8'h00;
   localparam logic [7:0] IER_RST = 8'h00;
   localparam logic [7:0] LCR_RST = 8'h19;
   localparam logic [7:0] MCR_RST = 8'h00;
   localparam logic [7:0] EFR_RST = 8'h00;
   localparam logic [7:0] FCR_RST = 8'h00;
   localparam logic [7:0] SPR_RST = 8'hff;
   localparam logic [15:0] DIV_RST = 16'h0001;

   // =========================================================
   // interrupt identification codes, bits 3:0
   localparam logic [3:0] IIR_NONE = 4'h1;
   localparam logic [3:0] IIR_RXDATA = 4'h4;
   localparam logic [3:0] IIR_THRE = 4'h2;
   localparam logic [3:0] IIR_MODEM = 4'h0;

   // =========================================================
   // timing
   localparam logic [3:0] OS_LAST = 4'hf;
   localparam logic [3:0] OS_MID = 4'h7;
   localparam logic [3:0] TX_START_BITS = 4'h8;
   localparam int CLK_NS = 25;
   localparam int RECEIVE_READY_INDICATION_CLR_NS = 1000;
   localparam int RECEIVE_READY_INDICATION_CLR_CYC = RECEIVE_READY_INDICATION_CLR_NS / CLK_NS;

   // =========================================================
   // state and select types
   typedef enum logic [2:0] {
      TX_IDLE = 3'b000,
      TX_WAIT = 3'b001,
      TX_START = 3'b010,
      TX_DATA = 3'b011,
      TX_STOP = 3'b100
   } uhri_tx_state_t;

   typedef enum logic [1:0] {
      RX_IDLE = 2'b00,
      RX_START = 2'b01,
      RX_DATA = 2'b10,
      RX_STOP = 2'b11
   } uhri_rx_state_t;

   typedef enum logic [3:0] {
      SEL_DATA = 4'b0000,
      SEL_DLL = 4'b0001,
      SEL_IER = 4'b0010,
      SEL_DLH = 4'b0011,
      SEL_IIR = 4'b0100,
      SEL_EFR = 4'b0101,
      SEL_LCR = 4'b0110,
      SEL_MCR = 4'b0111,
      SEL_LSR = 4'b1000,
      SEL_MSR = 4'b1001,
      SEL_SPR = 4'b1010
   } uhri_sel_t;

   // register select from address and the qualifying line control value
   function automatic uhri_sel_t uhri_decode(input logic [2:0] addr, input logic [7:0] line_control);
      uhri_sel_t sel;
      sel = SEL_SPR;
      case (addr)
         OFS_DATA: sel = line_control[LCR_DLAB_BIT] ? SEL_DLL : SEL_DATA;
         OFS_IER: sel = line_control[LCR_DLAB_BIT] ? SEL_DLH : SEL_IER;
         OFS_IIR: sel = (line_control == LCR_EFR_KEY) ? SEL_EFR : SEL_IIR;
         OFS_LCR: sel = SEL_LCR;
         OFS_MCR: sel = SEL_MCR;
         OFS_LSR: sel = SEL_LSR;
         OFS_MSR: sel = SEL_MSR;
         default: sel = SEL_SPR;
      endcase
      return sel;
   endfunction
endpackage

// ### core/uhri_fifo_if.sv
/*
 * Valid/ready carrier between the register interface and its transmit FIFO.
 * Assumes both ends run on the same clock.
 */
`timescale 1ns/1ps
`default_nettype none
interface uhri_fifo_if #(parameter int WIDTH = 8);
   logic [WIDTH-1:0] in_data;
   logic in_valid;
   logic in_ready;
   logic [WIDTH-1:0] out_data;
   logic out_valid;
   logic out_ready;
   modport store (input in_data, input in_valid, output in_ready,
                  output out_data, output out_valid, input out_ready);
   modport user (output in_data, output in_valid, input in_ready,
                 input out_data, input out_valid, output out_ready);
endinterface
`default_nettype wire

// ### core/uhri_fifo.sv
/*
 * Flip-flop FIFO with valid/ready on both sides.
 * Assumes one clock; in_ready low means full, out_valid low means empty.
 */
`timescale 1ns/1ps
`default_nettype none
module uhri_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 8
) (
   input wire logic mclk,
   input wire logic rst_b,
   uhri_fifo_if.store port
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem_ff [DEPTH];
   logic [AW-1:0] wr_ptr_ff;
   logic [AW-1:0] rd_ptr_ff;
   logic [AW:0] count_ff;
   logic push;
   logic pop;

   assign port.in_ready = (count_ff != (AW+1)'(DEPTH));
   assign port.out_valid = (count_ff != '0);
   assign port.out_data = mem_ff[rd_ptr_ff];
   assign push = port.in_valid && port.in_ready;
   assign pop = port.out_valid && port.out_ready;

   always_ff @(posedge mclk) begin
      if (push) begin
         mem_ff[wr_ptr_ff] <= port.in_data;
      end
   end

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         wr_ptr_ff <= '0;
         rd_ptr_ff <= '0;
         count_ff <= '0;
      end else begin
         if (push) begin
            wr_ptr_ff <= (wr_ptr_ff == AW'(DEPTH - 1)) ? '0 : wr_ptr_ff + AW'(1);
         end
         if (pop) begin
            rd_ptr_ff <= (rd_ptr_ff == AW'(DEPTH - 1)) ? '0 : rd_ptr_ff + AW'(1);
         end
         count_ff <= count_ff + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
endmodule
`default_nettype wire

// ### core/uhri_top.sv
/*
 * Host register interface of one asynchronous serial channel: indirect
 * register decode, interrupt identification, ready indications, and a
 * minimal 8N1 transmitter and receiver that produce the timed events.
 * Assumes host strobes and pins are synchronous to mclk; the host drives
 * address and cs_b stable while a strobe is low.
 */
`timescale 1ns/1ps
`default_nettype none
module uhri_top
   import uhri_pkg::*;
#(
   parameter int FIFO_DEPTH = 8
) (
   input wire logic mclk,
   input wire logic rst_b,
   input wire logic cs_b,
   input wire logic [2:0] addr,
   input wire logic read_strobe_b,
   input wire logic write_strobe_b,
   input wire logic [7:0] data_in,
   output logic [7:0] data_out,
   output logic data_oe,
   output logic int_out,
   output logic rx_ready,
   output logic tx_ready,
   input wire logic rx_in,
   output logic tx_out,
   input wire logic cts_b,
   input wire logic dsr_b,
   input wire logic ri_b,
   input wire logic cd_b,
   output logic rts_b,
   output logic dtr_b
);
   import uhri_pkg::*;

   // =========================================================
   // host strobe tracking
   logic rd_prev_ff, wr_prev_ff;
   logic [2:0] addr_ff;
   logic [7:0] wdata_ff;
   logic rd_done, wr_done;
   uhri_sel_t sel;
   logic [7:0] ier_ff, lcr_ff, mcr_ff, efr_ff, fcr_ff, spr_ff, rx_hold_ff;
   logic [15:0] div_ff;

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         rd_prev_ff <= 1'b0;
         wr_prev_ff <= 1'b0;
         addr_ff <= '0;
         wdata_ff <= '0;
      end else begin
         rd_prev_ff <= !read_strobe_b && !cs_b;
         wr_prev_ff <= !write_strobe_b && !cs_b;
         if ((!read_strobe_b || !write_strobe_b) && !cs_b) begin
            addr_ff <= addr;
            wdata_ff <= data_in;
         end
      end
   end

   // access takes effect as the strobe is released
   assign rd_done = rd_prev_ff && read_strobe_b;
   assign wr_done = wr_prev_ff && write_strobe_b;
   assign sel = uhri_decode(addr_ff, lcr_ff);

   // =========================================================
   // writable registers
   logic enh;
   assign enh = efr_ff[EFR_ENH_BIT];

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         ier_ff <= IER_RST;
         lcr_ff <= LCR_RST;
         mcr_ff <= MCR_RST;
         efr_ff <= EFR_RST;
         fcr_ff <= FCR_RST;
         spr_ff <= SPR_RST;
         div_ff <= DIV_RST;
      end else if (wr_done) begin
         case (sel)
            SEL_DLL: div_ff[7:0] <= wdata_ff;
            SEL_DLH: div_ff[15:8] <= wdata_ff;
            SEL_IER: ier_ff <= enh ? wdata_ff : ((ier_ff & IER_GUARD_MASK) |
                                                 (wdata_ff & ~IER_GUARD_MASK));
            SEL_IIR: fcr_ff <= enh ? wdata_ff : ((fcr_ff & FCR_GUARD_MASK) |
                                                 (wdata_ff & ~FCR_GUARD_MASK));
            SEL_MCR: mcr_ff <= enh ? wdata_ff : ((mcr_ff & MCR_GUARD_MASK) |
                                                 (wdata_ff & ~MCR_GUARD_MASK));
            SEL_EFR: efr_ff <= wdata_ff;
            SEL_LCR: lcr_ff <= wdata_ff;
            SEL_SPR: spr_ff <= wdata_ff;
            default: ;
         endcase
      end
   end

   // =========================================================
   // baud timing: sub-tick every div_ff clocks, bit tick every 16
   logic [15:0] sub_cnt_ff;
   logic [3:0] os_cnt_ff;
   logic sub_tick, bit_tick;

   assign sub_tick = (sub_cnt_ff <= 16'h0001);
   assign bit_tick = sub_tick && (os_cnt_ff == OS_LAST);

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         sub_cnt_ff <= 16'h0001;
         os_cnt_ff <= '0;
      end else begin
         sub_cnt_ff <= sub_tick ? div_ff : sub_cnt_ff - 16'h0001;
         if (sub_tick) begin
            os_cnt_ff <= os_cnt_ff + 4'h1;
         end
      end
   end

   // =========================================================
   // receiver
   uhri_rx_state_t rx_st_ff;
   logic [3:0] rx_os_ff;
   logic [2:0] rx_bit_ff;
   logic [7:0] rx_shift_ff;
   logic rx_done_ff, rx_full_ff;
   logic rd_data;

   assign rd_data = rd_done && (sel == SEL_DATA);

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         rx_st_ff <= RX_IDLE;
         rx_os_ff <= '0;
         rx_bit_ff <= '0;
         rx_shift_ff <= '0;
         rx_hold_ff <= DATA_RST;
         rx_done_ff <= 1'b0;
      end else begin
         rx_done_ff <= 1'b0;
         if (sub_tick) begin
            rx_os_ff <= rx_os_ff + 4'h1;
            case (rx_st_ff)
               RX_IDLE: begin
                  rx_os_ff <= '0;
                  if (!rx_in) begin
                     rx_st_ff <= RX_START;
                  end
               end
               RX_START: if (rx_os_ff == OS_MID) begin
                  rx_os_ff <= '0;
                  rx_bit_ff <= '0;
                  rx_st_ff <= rx_in ? RX_IDLE : RX_DATA;
               end
               RX_DATA: if (rx_os_ff == OS_LAST) begin
                  rx_shift_ff <= {rx_in, rx_shift_ff[7:1]};
                  rx_bit_ff <= rx_bit_ff + 3'h1;
                  if (rx_bit_ff == 3'h7) begin
                     rx_st_ff <= RX_STOP;
                  end
               end
               RX_STOP: if (rx_os_ff == OS_LAST) begin
                  rx_hold_ff <= rx_shift_ff;
                  rx_done_ff <= 1'b1;
                  rx_st_ff <= RX_IDLE;
               end
               default: rx_st_ff <= RX_IDLE;
            endcase
         end
      end
   end

   // arrival wins over a read in the same cycle
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         rx_full_ff <= 1'b0;
      end else if (rx_done_ff) begin
         rx_full_ff <= 1'b1;
      end else if (rd_data) begin
         rx_full_ff <= 1'b0;
      end
   end

   // =========================================================
   // transmit FIFO and transmitter
   uhri_fifo_if #(.WIDTH(8)) txq ();
   uhri_tx_state_t tx_st_ff;
   logic [3:0] tx_wait_ff;
   logic [2:0] tx_bit_ff;
   logic [7:0] tx_shift_ff;
   logic tx_load, tx_empty_evt, thre_pend_ff, wr_data;

   uhri_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_txq (
      .mclk(mclk),
      .rst_b(rst_b),
      .port(txq.store)
   );

   assign wr_data = wr_done && (sel == SEL_DATA);
   assign txq.in_valid = wr_data; // characters written while full are lost
   assign txq.in_data = wdata_ff;
   assign tx_load = bit_tick && txq.out_valid &&
                    (((tx_st_ff == TX_WAIT) && (tx_wait_ff == TX_START_BITS)) ||
                     (tx_st_ff == TX_STOP));
   assign txq.out_ready = tx_load;
   assign tx_empty_evt = bit_tick && (tx_st_ff == TX_STOP) && !txq.out_valid;

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         tx_st_ff <= TX_IDLE;
         tx_wait_ff <= '0;
         tx_bit_ff <= '0;
         tx_shift_ff <= '0;
         tx_out <= 1'b1;
      end else begin
         if (tx_load) begin
            tx_shift_ff <= txq.out_data;
            tx_st_ff <= TX_START;
            tx_out <= 1'b0;
         end else begin
            case (tx_st_ff)
               TX_IDLE: begin
                  tx_wait_ff <= '0;
                  if (txq.out_valid) begin
                     tx_st_ff <= TX_WAIT;
                  end
               end
               TX_WAIT: if (bit_tick) begin
                  tx_wait_ff <= tx_wait_ff + 4'h1;
               end
               TX_START: if (bit_tick) begin
                  tx_out <= tx_shift_ff[0];
                  tx_shift_ff <= {1'b1, tx_shift_ff[7:1]};
                  tx_bit_ff <= '0;
                  tx_st_ff <= TX_DATA;
               end
               TX_DATA: if (bit_tick) begin
                  tx_bit_ff <= tx_bit_ff + 3'h1;
                  if (tx_bit_ff == 3'h7) begin
                     tx_out <= 1'b1;
                     tx_st_ff <= TX_STOP;
                  end else begin
                     tx_out <= tx_shift_ff[0];
                     tx_shift_ff <= {1'b1, tx_shift_ff[7:1]};
                  end
               end
               TX_STOP: if (tx_empty_evt) begin
                  tx_st_ff <= TX_IDLE;
               end
               default: tx_st_ff <= TX_IDLE;
            endcase
         end
      end
   end

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         thre_pend_ff <= 1'b0;
      end else if (tx_empty_evt) begin
         thre_pend_ff <= 1'b1;
      end else if (wr_data) begin
         thre_pend_ff <= 1'b0;
      end
   end

   // =========================================================
   // modem status change detection
   logic [3:0] modem_b, modem_prev_ff, delta_ff;
   logic rd_msr;
   assign modem_b = {cd_b, ri_b, dsr_b, cts_b};
   assign rd_msr = rd_done && (sel == SEL_MSR);

   for (genvar i = 0; i < 4; i++) begin : g_delta
      always_ff @(posedge mclk or negedge rst_b) begin
         if (!rst_b) begin
            modem_prev_ff[i] <= 1'b1;
            delta_ff[i] <= 1'b0;
         end else begin
            modem_prev_ff[i] <= modem_b[i];
            if (modem_b[i] != modem_prev_ff[i]) begin
               delta_ff[i] <= 1'b1;
            end else if (rd_msr) begin
               delta_ff[i] <= 1'b0;
            end
         end
      end
   end

   // =========================================================
   // interrupt identification and read data
   logic pend_rx, pend_thre, pend_ms;
   logic [7:0] iir_val, rd_val;
   assign pend_rx = ier_ff[IER_RX_BIT] && rx_full_ff;
   assign pend_thre = ier_ff[IER_THRE_BIT] && thre_pend_ff;
   assign pend_ms = ier_ff[IER_MS_BIT] && (delta_ff != '0);

   always_comb begin
      iir_val = {{2{fcr_ff[FCR_EN_BIT]}}, 2'b00, IIR_NONE};
      if (pend_rx) begin
         iir_val[3:0] = IIR_RXDATA;
      end else if (pend_thre) begin
         iir_val[3:0] = IIR_THRE;
      end else if (pend_ms) begin
         iir_val[3:0] = IIR_MODEM;
      end
   end

   always_comb begin
      case (sel)
         SEL_DATA: rd_val = rx_hold_ff;
         SEL_DLL: rd_val = div_ff[7:0];
         SEL_IER: rd_val = ier_ff;
         SEL_DLH: rd_val = div_ff[15:8];
         SEL_IIR: rd_val = iir_val;
         SEL_EFR: rd_val = efr_ff;
         SEL_LCR: rd_val = lcr_ff;
         SEL_MCR: rd_val = mcr_ff;
         SEL_LSR: rd_val = {1'b0, !txq.out_valid && (tx_st_ff == TX_IDLE),
                            !txq.out_valid, 4'h0, rx_full_ff};
         SEL_MSR: rd_val = {~modem_b, delta_ff};
         SEL_SPR: rd_val = spr_ff;
         default: rd_val = 8'h00;
      endcase
   end

   // =========================================================
   // registered outputs
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         data_out <= 8'h00;
         data_oe <= 1'b0;
         int_out <= 1'b0;
         rx_ready <= 1'b0;
         tx_ready <= 1'b0;
         rts_b <= 1'b1;
         dtr_b <= 1'b1;
      end else begin
         data_out <= rd_prev_ff ? rd_val : 8'h00;
         data_oe <= rd_prev_ff && !read_strobe_b;
         int_out <= pend_rx || pend_thre || pend_ms;
         rx_ready <= rx_full_ff;
         tx_ready <= txq.in_ready;
         rts_b <= !mcr_ff[1];
         dtr_b <= !mcr_ff[0];
      end
   end

   // =========================================================
   // checks
   localparam int RDY_CLR = RECEIVE_READY_INDICATION_CLR_CYC;

   sequence s_rd_data;
      rd_data && !rx_done_ff;
   endsequence

   sequence s_msr_clear;
      rd_msr && (modem_b == modem_prev_ff) ##1 (modem_b == modem_prev_ff) [*2];
   endsequence

   a_rx_ready_set: assert property (@(posedge mclk) disable iff (!rst_b)
      rx_done_ff |-> ##2 rx_ready) else $error("receive ready not raised");
   a_rx_ready_clr: assert property (@(posedge mclk) disable iff (!rst_b)
      s_rd_data ##1 !rx_done_ff |-> ##[1:RDY_CLR] !rx_ready)
      else $error("receive ready not withdrawn");
   a_rx_int_set: assert property (@(posedge mclk) disable iff (!rst_b)
      rx_done_ff && ier_ff[IER_RX_BIT] |-> ##2 int_out)
      else $error("receive interrupt missing");
   a_rx_int_clr: assert property (@(posedge mclk) disable iff (!rst_b)
      s_rd_data |=> !rx_full_ff) else $error("receive interrupt not withdrawn");
   a_thre_set: assert property (@(posedge mclk) disable iff (!rst_b)
      tx_empty_evt |=> thre_pend_ff) else $error("transmit empty not flagged");
   a_thre_clr: assert property (@(posedge mclk) disable iff (!rst_b)
      wr_data && !tx_empty_evt |=> !thre_pend_ff) else $error("transmit empty kept");
   a_tx_start_wait: assert property (@(posedge mclk) disable iff (!rst_b)
      $rose(tx_st_ff == TX_START) && $past(tx_st_ff) == TX_WAIT |->
      $past(tx_wait_ff) == TX_START_BITS) else $error("start latency short");
   a_tx_ready_full: assert property (@(posedge mclk) disable iff (!rst_b)
      !txq.in_ready |=> !tx_ready) else $error("transmit ready with full store");
   a_tx_ready_back: assert property (@(posedge mclk) disable iff (!rst_b)
      tx_load |-> ##2 tx_ready) else $error("transmit ready not returned");
   a_ier_guard: assert property (@(posedge mclk) disable iff (!rst_b)
      wr_done && sel == SEL_IER && !enh |=> ier_ff[7:4] == $past(ier_ff[7:4]))
      else $error("guarded enable bits changed");
   a_msr_int: assert property (@(posedge mclk) disable iff (!rst_b)
      (modem_b != modem_prev_ff) && ier_ff[IER_MS_BIT] |-> ##2 int_out)
      else $error("modem interrupt missing");
   a_msr_clear: assert property (@(posedge mclk) disable iff (!rst_b)
      s_msr_clear |-> delta_ff == '0) else $error("modem status not cleared");
   a_iir_idle: assert property (@(posedge mclk) disable iff (!rst_b)
      rd_prev_ff && sel == SEL_IIR |=>
      data_out[0] == !$past(pend_rx || pend_thre || pend_ms))
      else $error("identification bit 0 disagrees with pending state");
   a_div_gate: assert property (@(posedge mclk) disable iff (!rst_b)
      addr_ff == OFS_DATA && !lcr_ff[LCR_DLAB_BIT] |-> sel == SEL_DATA)
      else $error("divisor visible without access bit");
endmodule
`default_nettype wire

// ### test/uhri_host.sv
/* host processor model on the strobed register bus.
   assumes the bench calls cyc and shares mclk. */
`timescale 1ns/1ps
`default_nettype none
module uhri_host (
   input wire logic mclk,
   output logic cs_b,
   output logic [2:0] addr,
   output logic read_strobe_b,
   output logic write_strobe_b,
   output logic [7:0] data_in,
   input wire logic [7:0] data_out,
   input wire logic data_oe
);
   // ==========================================
   // bus cycles
   initial begin
      cs_b = 1'b1;
      addr = 3'h0;
      read_strobe_b = 1'b1;
      write_strobe_b = 1'b1;
      data_in = 8'h00;
   end
   // request held three edges, then two idle edges
   task automatic cyc(input logic wr, input logic [2:0] a, input logic [7:0] d,
                      output logic [7:0] q);
      @(posedge mclk);
      #1;
      cs_b = 1'b0;
      addr = a;
      data_in = d;
      if (wr) write_strobe_b = 1'b0;
      else read_strobe_b = 1'b0;
      repeat (3) @(posedge mclk);
      #1;
      // a bus not driven reads back inverted so that the compare trips
      q = data_oe ? data_out : ~data_out;
      write_strobe_b = 1'b1;
      read_strobe_b = 1'b1;
      cs_b = 1'b1;
      data_in = ~d;
      repeat (2) @(posedge mclk);
      #1;
   endtask
endmodule
`default_nettype wire

// ### test/tb_uhri_top.sv
/* self-checking bench for the host register interface.
   assumes divisor 1, so one bit time is 16 mclk. */
`timescale 1ns/1ps
`default_nettype none
module tb_uhri_top;
   import uhri_pkg::*;
   logic mclk = 1'b0, rst_b = 1'b0, cs_b, read_strobe_b, write_strobe_b;
   logic [2:0] addr;
   logic [7:0] data_in, data_out, q;
   logic data_oe, int_out, rx_ready, tx_ready, tx_out, rts_b, dtr_b;
   logic rx_in = 1'b1, cts_b = 1'b1, dsr_b = 1'b1, ri_b = 1'b1, cd_b = 1'b1;
   int mismatches = 0, checked = 0, n;
   uhri_host host (.mclk(mclk), .cs_b(cs_b), .addr(addr), .read_strobe_b(read_strobe_b),
      .write_strobe_b(write_strobe_b), .data_in(data_in), .data_out(data_out),
      .data_oe(data_oe));
   uhri_top #(.FIFO_DEPTH(8)) uut (.mclk(mclk), .rst_b(rst_b), .cs_b(cs_b), .addr(addr),
      .read_strobe_b(read_strobe_b), .write_strobe_b(write_strobe_b), .data_in(data_in),
      .data_out(data_out), .data_oe(data_oe), .int_out(int_out), .rx_ready(rx_ready),
      .tx_ready(tx_ready), .rx_in(rx_in), .tx_out(tx_out), .cts_b(cts_b), .dsr_b(dsr_b),
      .ri_b(ri_b), .cd_b(cd_b), .rts_b(rts_b), .dtr_b(dtr_b));
   always #12.5 mclk = ~mclk;
   // ==========================================
   // helpers
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      checked++;
      if (seen !== exp) begin
         mismatches++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic conclude();
      $display("checked=%0d mismatches=%0d", checked, mismatches);
      if (mismatches == 0 && checked > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      host.cyc(1'b1, a, d, q);
   endtask
   task automatic rd(input logic [2:0] a);
      host.cyc(1'b0, a, 8'h00, q);
   endtask
   task automatic waitv(ref logic s, input logic v, input int lim, output int k);
      k = 0;
      while (s !== v && k < lim) begin
         @(posedge mclk);
         #1;
         k++;
      end
      if (s !== v) begin
         mismatches++;
         conclude();
      end
   endtask
   task automatic send(input logic [7:0] d);
      for (int i = 0; i < 10; i++) begin
         rx_in = (i == 0) ? 1'b0 : (i == 9) ? 1'b1 : d[i-1];
         repeat (16) @(posedge mclk);
         #1;
      end
   endtask
   // ==========================================
   // scenarios
   task automatic t_map();
      rd(OFS_IER); check(q, 8'h00);
      rd(OFS_IIR); check(q, 8'h01);
      wr(OFS_IER, 8'h05);
      wr(OFS_LCR, 8'h80);
      wr(OFS_DATA, 8'h01);
      wr(OFS_IER, 8'h00);
      rd(OFS_DATA); check(q, 8'h01);
      rd(OFS_IER); check(q, 8'h00);
      wr(OFS_LCR, 8'h03);
      rd(OFS_IER); check(q, 8'h05);
   endtask
   task automatic t_guard();
      wr(OFS_MCR, 8'he3);
      rd(OFS_MCR); check(q, 8'h03);
      check({6'h00, rts_b, dtr_b}, 8'h00);
      wr(OFS_IER, 8'hff);
      rd(OFS_IER); check(q, 8'h0f);
      wr(OFS_LCR, 8'hbf);
      wr(OFS_IIR, 8'h10);
      wr(OFS_LCR, 8'h03);
      wr(OFS_IER, 8'hff);
      rd(OFS_IER); check(q, 8'hff);
   endtask
   task automatic t_rx();
      wr(OFS_IER, 8'h01);
      send(8'ha5);
      waitv(rx_ready, 1'b1, 16, n);
      check(int_out, 1'b1);
      rd(OFS_IIR); check(q, 8'h04);
      rd(OFS_DATA); check(q, 8'ha5);
      check(int_out, 1'b0);
      waitv(rx_ready, 1'b0, 36, n);
   endtask
   task automatic t_tx();
      wr(OFS_DATA, 8'h3c);
      wr(OFS_IER, 8'h02);
      waitv(tx_out, 1'b0, 400, n);
      check(n + 8 >= 128 && n + 8 <= 384, 1'b1);
      waitv(int_out, 1'b1, 180, n);
      rd(OFS_IIR); check(q, 8'h02);
      wr(OFS_DATA, 8'h81);
      check(int_out, 1'b0);
      for (int i = 0; i < 8; i++) wr(OFS_DATA, 8'(i));
      check(tx_ready, 1'b0);
      waitv(tx_ready, 1'b1, 640, n);
   endtask
   task automatic t_modem();
      wr(OFS_IER, 8'h08);
      cts_b = 1'b0;
      waitv(int_out, 1'b1, 4, n);
      rd(OFS_MSR); check(q, 8'h11);
      check(int_out, 1'b0);
   endtask
   initial begin
      repeat (3) @(posedge mclk);
      #1;
      rst_b = 1'b1;
      repeat (2) @(posedge mclk);
      t_map();
      t_guard();
      t_rx();
      t_tx();
      t_modem();
      conclude();
   end
endmodule
`default_nettype wire
